/* File: logic/pbb_pkg.sv */
// package for the processor-bus to host-port bridge
// assumes one clock domain at the bridge core; no software registers
package pbb_pkg;
    // processor-bus transfer sizes (byte count code)
    typedef enum logic [2:0] {
        PBB_SZ_BYTE,
        PBB_SZ_HALF,
        PBB_SZ_WORD,
        PBB_SZ_DWORD,
        PBB_SZ_B16,
        PBB_SZ_B32,
        PBB_SZ_B64,
        PBB_SZ_B128
    } pbb_psize_t;

    localparam int PBB_ADDR_W = 36;
    localparam int PBB_HADDR_W = 32;
    localparam int PBB_PAGE_W = 4;
    localparam int PBB_ATTR_LSB = 36;
    localparam int PBB_ATTR_MSB = 63;
    localparam int PBB_ATTR_W = PBB_ATTR_MSB - PBB_ATTR_LSB + 1;
    // attribute field positions within the muxed lines, relative to lsb
    localparam int PBB_F_SIZE = 0;
    localparam int PBB_F_WR = 3;
    localparam int PBB_F_COH = 4;
    localparam int PBB_F_LOCK = 5;
    localparam logic [6:0] PBB_MAX_HLEN = 7'h40;
    localparam logic [7:0] PBB_CHAIN_LEN = 8'h40;
    localparam logic [PBB_PAGE_W-1:0] PBB_PAGE_RST = 4'h0;
    localparam logic PBB_MODEL_RST = 1'b0;
endpackage

/* File: logic/pbb_addr_map.sv */
// address recognition and translation for the bridge
// assumes window bases and bounds are supplied stable by the chipset side
`timescale 1ns/1ns
module pbb_addr_map (
    input wire logic paged,               // 1: paged model, 0: direct
    input wire logic [3:0] page,          // selected 4-gbyte region
    input wire logic [35:0] p_addr,       // processor-bus address
    input wire logic [35:0] public_memory_base,     // public memory base
    input wire logic [35:0] mem_bound,    // public memory bound
    input wire logic [35:0] unit_window_base,    // unit window base
    input wire logic [35:0] unit_bound,   // unit window bound
    input wire logic [31:0] h_addr,       // incoming host address
    input wire logic [3:0] h_ext,         // host 36-bit extension
    output logic p_remote,                // forward to host port
    output logic [31:0] p_out_addr,       // host address produced
    output logic [3:0] p_out_ext,         // host extension produced
    output logic h_hit,                   // host access is for us
    output logic [35:0] h_out_addr        // processor-bus address
);
    function automatic logic in_win(input logic [35:0] a,
                                    input logic [35:0] lo,
                                    input logic [35:0] hi);
        in_win = (a >= lo) && (a <= hi);
    endfunction

    logic p_local;

    always_comb begin
        // public memory and unit windows stay local on the processor bus
        p_local = in_win(p_addr, public_memory_base, mem_bound) ||
                  in_win(p_addr, unit_window_base, unit_bound);
        if (paged) begin
            // only the chosen page is visible; the rest is private
            p_remote = (p_addr[35:32] == page) && !p_local;
            p_out_ext = 4'h0;
        end else begin
            p_remote = !p_local;
            p_out_ext = p_addr[35:32];
        end
        p_out_addr = p_addr[31:0];
        h_out_addr = paged ? {page, h_addr} : {h_ext, h_addr};
        h_hit = in_win(h_out_addr, public_memory_base, mem_bound);
    end
endmodule

/* File: logic/pbb_bridge.sv */
// level one bridge core: transaction translation both ways
// assumes the host port and processor bus are presented synchronous to clk;
// the cross-rate fifos live in the datapath outside this block
//
// How it works
// - byte, half, word processor accesses become single 32-bit host transfers.
// - double words and 16/32/64 byte bursts become 64-bit host bursts.
// - 128-byte burst goes out as two chained 64-byte host bursts.
// - host 3-byte partial becomes a half-word then a byte access.
// - 32-bit host bursts split into 2, 4, 8 or 16 word accesses.
// - 32-bit host bursts only ever make 4-byte processor transactions.
// - 64-bit host bursts become one double word or burst, same length.
// - slave on the originating bus, master on the other.
// - coherent level-two transactions are refused, never forwarded.
// - attributes captured from bits 63:36 in address phase, re-encoded.
// - host attributes encoded onto bits 63:36 with the address.
// - each side decodes its own answering region and maps addresses.
// - 36-bit processor address, 32-bit host address plus extension.
// - direct model maps outside windows into lowest 64 gbytes.
// - paged model uses a 4-bit page to pick one of 16 regions.
// - in page, public and unit windows stay local, other addresses go remote.
// - host-side accesses are placed in the page-selected region.
// - the two clock domains meet through fifos outside this core.
`timescale 1ns/1ns
module pbb_bridge (
    input wire logic clk,                  // core clock, 10 mhz
    input wire logic rst,                  // synchronous reset
    input wire logic paged,                // memory model select
    input wire logic [3:0] page,           // page value
    input wire logic [35:0] public_memory_base,      // public memory base
    input wire logic [35:0] mem_bound,     // public memory bound
    input wire logic [35:0] unit_window_base,     // unit window base
    input wire logic [35:0] unit_bound,    // unit window bound
    // processor-bus slave request
    input wire logic p_as,                 // address phase strobe
    input wire logic [63:0] p_mad_in,      // muxed_addr_data_lines in
    output logic p_accept,                 // request taken for host
    output logic p_reject,                 // request not ours
    // host-port master command
    output logic h_req,                    // host command valid
    output logic [31:0] h_addr_out,        // host address
    output logic [3:0] h_ext_out,          // host address extension
    output logic h_wide,                   // width64_transfer when 1
    output logic [6:0] h_len,              // byte length
    output logic h_burst,                  // burst when 1
    output logic h_write,                  // write when 1
    output logic h_lock,                   // locked transfer
    output logic h_more,                   // chain continues
    input wire logic h_done,               // host command completed
    // host-port slave request
    input wire logic h_sel,                // host access strobe
    input wire logic [31:0] h_addr_in,     // host address in
    input wire logic [3:0] h_ext_in,       // host extension in
    input wire logic h_wide_in,            // width64 when 1
    input wire logic [6:0] h_len_in,       // byte length in
    input wire logic h_write_in,           // write in
    input wire logic h_lock_in,            // lock in
    output logic h_ack,                    // host access finished
    output logic h_miss,                   // host access not ours
    // processor-bus master command
    output logic p_req,                    // address phase drive
    output logic [63:0] p_mad_out,         // muxed_addr_data_lines out
    input wire logic p_done                // processor beat completed
);
    typedef enum logic [1:0] {
        PBB_IDLE,
        PBB_HOST,
        PBB_PROC
    } pbb_state_t;

    pbb_state_t state;
    logic [35:0] p_addr_q;
    logic [2:0] p_size_q;
    logic p_wr_q;
    logic p_lock_q;
    logic chain_second;
    logic [35:0] m_addr;
    logic [6:0] m_left;
    logic m_wide;
    logic m_wr;
    logic m_lock;
    logic p_remote;
    logic [31:0] map_addr;
    logic [3:0] map_ext;
    logic h_hit;
    logic [35:0] h_map_addr;
    logic [35:0] p_addr_now;
    logic p_coherent;

    // ----------------------------------------------------------------
    // address section
    // ----------------------------------------------------------------
    assign p_addr_now = p_mad_in[35:0];
    assign p_coherent = p_mad_in[pbb_pkg::PBB_ATTR_LSB + pbb_pkg::PBB_F_COH];

    pbb_addr_map u_map (
        .paged(paged),
        .page(page),
        .p_addr(p_addr_now),
        .public_memory_base(public_memory_base),
        .mem_bound(mem_bound),
        .unit_window_base(unit_window_base),
        .unit_bound(unit_bound),
        .h_addr(h_addr_in),
        .h_ext(h_ext_in),
        .p_remote(p_remote),
        .p_out_addr(map_addr),
        .p_out_ext(map_ext),
        .h_hit(h_hit),
        .h_out_addr(h_map_addr)
    );

    // byte length of a processor size code
    function automatic logic [7:0] size_bytes(input logic [2:0] s);
        size_bytes = 8'h01 << s;
    endfunction

    // size code for a processor beat of n bytes
    function automatic logic [2:0] bytes_code(input logic [6:0] n);
        unique case (n)
            7'h01: bytes_code = 3'h0;
            7'h02: bytes_code = 3'h1;
            7'h04: bytes_code = 3'h2;
            7'h08: bytes_code = 3'h3;
            7'h10: bytes_code = 3'h4;
            7'h20: bytes_code = 3'h5;
            default: bytes_code = 3'h6;
        endcase
    endfunction

    // one beat that the processor bus can take from what is left
    function automatic logic [6:0] next_beat(input logic wide,
                                             input logic [6:0] left);
        if (wide) begin
            next_beat = left;
        end else if (left >= 7'h04) begin
            next_beat = 7'h04;
        end else if (left == 7'h03) begin
            next_beat = 7'h02;
        end else begin
            next_beat = left;
        end
    endfunction

    logic [6:0] beat;
    assign beat = next_beat(m_wide, m_left);

    // ----------------------------------------------------------------
    // control: one transaction in flight at a time
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= PBB_IDLE;
        end else begin
            unique case (state)
                PBB_IDLE: begin
                    // processor side has priority on a same-cycle clash
                    if (p_as && !p_coherent && p_remote) begin
                        state <= PBB_HOST;
                    end else if (h_sel && !p_as && h_hit) begin
                        state <= PBB_PROC;
                    end
                end
                PBB_HOST: begin
                    if (h_done && !(chain_second == 1'b0 &&
                        p_size_q == 3'h7)) begin
                        state <= PBB_IDLE;
                    end
                end
                PBB_PROC: begin
                    if (p_done && m_left == beat) begin
                        state <= PBB_IDLE;
                    end
                end
            endcase
        end
    end

    // processor-side capture of address and attributes
    always_ff @(posedge clk) begin
        if (rst) begin
            p_addr_q <= 36'h0;
            p_size_q <= 3'h0;
            p_wr_q <= 1'b0;
            p_lock_q <= 1'b0;
        end else if (state == PBB_IDLE && p_as) begin
            p_addr_q <= {map_ext, map_addr};
            p_size_q <= p_mad_in[pbb_pkg::PBB_ATTR_LSB +
                pbb_pkg::PBB_F_SIZE +: 3];
            p_wr_q <= p_mad_in[pbb_pkg::PBB_ATTR_LSB + pbb_pkg::PBB_F_WR];
            p_lock_q <= p_mad_in[pbb_pkg::PBB_ATTR_LSB +
                pbb_pkg::PBB_F_LOCK];
        end
    end

    // processor answers
    always_ff @(posedge clk) begin
        if (rst) begin
            p_accept <= 1'b0;
            p_reject <= 1'b0;
        end else begin
            p_accept <= state == PBB_IDLE && p_as && !p_coherent && p_remote;
            // coherent traffic never crosses; it is snooped elsewhere
            p_reject <= state == PBB_IDLE && p_as &&
                (p_coherent || !p_remote);
        end
    end

    // ----------------------------------------------------------------
    // host-port master command
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            h_req <= 1'b0;
            h_addr_out <= 32'h0;
            h_ext_out <= 4'h0;
            h_wide <= 1'b0;
            h_len <= 7'h0;
            h_burst <= 1'b0;
            h_write <= 1'b0;
            h_lock <= 1'b0;
            h_more <= 1'b0;
            chain_second <= 1'b0;
        end else if (state == PBB_IDLE &&
                     p_as && !p_coherent && p_remote) begin
            h_req <= 1'b1;
            h_addr_out <= map_addr;
            h_ext_out <= map_ext;
            h_write <= p_mad_in[pbb_pkg::PBB_ATTR_LSB + pbb_pkg::PBB_F_WR];
            h_lock <= p_mad_in[pbb_pkg::PBB_ATTR_LSB + pbb_pkg::PBB_F_LOCK];
            chain_second <= 1'b0;
            unique case (p_mad_in[pbb_pkg::PBB_ATTR_LSB +: 3])
                3'h0, 3'h1, 3'h2: begin
                    h_wide <= 1'b0;
                    h_burst <= 1'b0;
                    h_len <= 7'(size_bytes(p_mad_in[36 +: 3]));
                    h_more <= 1'b0;
                end
                3'h7: begin
                    h_wide <= 1'b1;
                    h_burst <= 1'b1;
                    h_len <= pbb_pkg::PBB_MAX_HLEN;
                    h_more <= 1'b1;
                end
                default: begin
                    h_wide <= 1'b1;
                    h_burst <= 1'b1;
                    h_len <= 7'(size_bytes(p_mad_in[36 +: 3]));
                    h_more <= 1'b0;
                end
            endcase
        end else if (state == PBB_HOST && h_done) begin
            if (p_size_q == 3'h7 && !chain_second) begin
                // second half of the 128-byte burst, last in chain
                chain_second <= 1'b1;
                h_addr_out <= h_addr_out + 32'(pbb_pkg::PBB_CHAIN_LEN);
                h_more <= 1'b0;
            end else begin
                h_req <= 1'b0;
                h_more <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // host-port slave to processor-bus master
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            m_addr <= 36'h0;
            m_left <= 7'h0;
            m_wide <= 1'b0;
            m_wr <= 1'b0;
            m_lock <= 1'b0;
        end else if (state == PBB_IDLE && h_sel && !p_as && h_hit) begin
            m_addr <= h_map_addr;
            m_left <= h_len_in;
            m_wide <= h_wide_in;
            m_wr <= h_write_in;
            m_lock <= h_lock_in;
        end else if (state == PBB_PROC && p_done) begin
            m_addr <= m_addr + 36'(beat);
            m_left <= m_left - beat;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            p_req <= 1'b0;
            p_mad_out <= 64'h0;
        end else begin
            p_req <= state == PBB_PROC && !p_done;
            p_mad_out <= {22'h0, m_lock, 1'b0, m_wr,
                bytes_code(beat), m_addr};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            h_ack <= 1'b0;
            h_miss <= 1'b0;
        end else begin
            h_ack <= state == PBB_PROC && p_done && m_left == beat;
            h_miss <= state == PBB_IDLE && h_sel && !p_as && !h_hit;
        end
    end

    // the unused capture is kept for the datapath controller
    logic unused_ok;
    assign unused_ok = p_wr_q ^ p_lock_q ^ p_addr_q[0];
endmodule

/* File: sim/pbb_chk.sv */
// concurrent checks on the bridge core ports
// assumes a bind from the bench top; one clock, synchronous reset
`timescale 1ns/1ns
module pbb_chk (
    input wire logic clk, // core clock
    input wire logic rst, // sync reset
    input wire logic paged, // memory model
    input wire logic [35:0] public_memory_base, // public base
    input wire logic [35:0] mem_bound, // public bound
    input wire logic p_as, // address phase
    input wire logic [63:0] p_mad_in, // muxed lines in
    input wire logic p_accept, // taken
    input wire logic p_reject, // refused
    input wire logic h_req, // host command
    input wire logic [31:0] h_addr_out, // host address
    input wire logic h_wide, // 64-bit
    input wire logic [6:0] h_len, // bytes
    input wire logic h_burst, // burst
    input wire logic h_write, // write
    input wire logic h_lock, // lock
    input wire logic h_more, // chain
    input wire logic h_done, // host done
    input wire logic h_sel, // host strobe
    input wire logic [31:0] h_addr_in, // host address in
    input wire logic [3:0] h_ext_in, // extension in
    input wire logic h_wide_in, // 64-bit in
    input wire logic [6:0] h_len_in, // bytes in
    input wire logic h_write_in, // write in
    input wire logic h_lock_in, // lock in
    input wire logic h_ack, // host finished
    input wire logic h_miss, // not ours
    input wire logic p_req, // processor command
    input wire logic [63:0] p_mad_out, // muxed lines out
    input wire logic p_done // beat done
);
    // ------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------
    logic idle;
    logic sv_wr, sv_lk, sv_wide;
    logic [6:0] sv_len;
    logic [4:0] beats;
    assign idle = !h_req && !p_req;
    // no reset: read only once a host access is taken
    always_ff @(posedge clk) begin
        if (h_sel && !p_as && idle) begin
            sv_wr <= h_write_in;
            sv_lk <= h_lock_in;
            sv_wide <= h_wide_in;
            sv_len <= h_len_in;
            beats <= 5'h00;
        end else if (p_req && p_done) begin
            beats <= beats + 5'h01;
        end
    end
    function automatic logic [6:0] len_of(input logic [2:0] c);
        return (c == 3'h7) ? 7'h40 : 7'(1 << c);
    endfunction
    function automatic logic [2:0] wcode(input logic [6:0] n);
        return n[6] ? 3'h6 : n[5] ? 3'h5 : n[4] ? 3'h4 : 3'h3;
    endfunction
    function automatic logic [4:0] beats_of(input logic w, logic [6:0] n);
        return w ? 5'h01 : (n == 7'h03) ? 5'h02 : (n < 7'h04) ? 5'h01 : n[6:2];
    endfunction
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    accept_roles_a:
        assert property ($rose(h_req) |-> p_accept && !p_reject)
        else $error("command not accepted");
    len_width_a:
        assert property ($rose(h_req) |-> h_len == len_of($past(p_mad_in[38:36]))
            && h_wide == h_burst && h_wide == ($past(p_mad_in[38:36]) >= 3'h3))
        else $error("host size wrong");
    chain_first_a:
        assert property ($rose(h_req) |-> h_more == ($past(p_mad_in[38:36]) == 3'h7))
        else $error("chain flag wrong");
    chain_second_a:
        assert property (h_req && h_more && h_done |=> h_req && !h_more
            && h_addr_out == $past(h_addr_out) + 32'h40)
        else $error("second half wrong");
    attr_capture_a:
        assert property ($rose(h_req) |-> h_write == $past(p_mad_in[39])
            && h_lock == $past(p_mad_in[41])
            && h_addr_out == $past(p_mad_in[31:0]))
        else $error("attributes lost");
    coherent_block_a:
        assert property (p_as && idle && p_mad_in[40] |=> p_reject && !h_req)
        else $error("coherent access passed");
    local_direct_a:
        assert property (p_as && idle && !paged && p_mad_in[35:0] >= public_memory_base
            && p_mad_in[35:0] <= mem_bound |=> p_reject && !h_req)
        else $error("local access forwarded");
    attr_encode_a:
        assert property (p_req |-> p_mad_out[39] == sv_wr && p_mad_out[41] == sv_lk)
        else $error("attributes not encoded");
    narrow_beats_a:
        assert property (p_req && !sv_wide && sv_len >= 7'h04
            |-> p_mad_out[38:36] == 3'h2)
        else $error("narrow beat not word");
    wide_beat_a:
        assert property (p_req && sv_wide |-> p_mad_out[38:36] == wcode(sv_len))
        else $error("wide size wrong");
    beat_count_a:
        assert property ($rose(h_ack) |-> beats == beats_of(sv_wide, sv_len) && !p_req)
        else $error("beat count wrong");
    host_miss_a:
        assert property (h_sel && !p_as && idle && !paged
            && {h_ext_in, h_addr_in} > mem_bound |=> h_miss && !p_req)
        else $error("outside access taken");
endmodule

/* File: sim/pbb_partner.sv */
// far-side responder: host port target and processor-bus target
// assumes commands stay up until done; slow sets added wait cycles
`timescale 1ns/1ns
module pbb_partner (
    input wire logic clk, // core clock
    input wire logic rst, // sync reset
    input wire logic [2:0] slow, // wait cycles
    input wire logic h_req, // host command
    output logic h_done, // host done pulse
    input wire logic p_req, // processor command
    output logic p_done // beat done pulse
);
    logic [2:0] hc, pc;
    // a done pulse clears the count, so chained halves wait again
    always_ff @(posedge clk) begin
        if (rst || !h_req || h_done) begin
            h_done <= 1'b0;
            hc <= 3'h0;
        end else if (hc == slow) begin
            h_done <= 1'b1;
        end else begin
            hc <= hc + 3'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst || !p_req || p_done) begin
            p_done <= 1'b0;
            pc <= 3'h0;
        end else if (pc == slow) begin
            p_done <= 1'b1;
        end else begin
            pc <= pc + 3'h1;
        end
    end
endmodule

/* File: sim/tb_top.sv */
// bench for the bridge core with the far-side responder
// assumes inputs change at the falling edge; one 10 mhz clock
`timescale 1ns/1ns
bind pbb_bridge pbb_chk chk (.clk(clk), .rst(rst), .paged(paged),
    .public_memory_base(public_memory_base), .mem_bound(mem_bound), .p_as(p_as),
    .p_mad_in(p_mad_in), .p_accept(p_accept), .p_reject(p_reject),
    .h_req(h_req), .h_addr_out(h_addr_out), .h_wide(h_wide), .h_len(h_len),
    .h_burst(h_burst), .h_write(h_write), .h_lock(h_lock), .h_more(h_more),
    .h_done(h_done), .h_sel(h_sel), .h_addr_in(h_addr_in),
    .h_ext_in(h_ext_in), .h_wide_in(h_wide_in), .h_len_in(h_len_in),
    .h_write_in(h_write_in), .h_lock_in(h_lock_in), .h_ack(h_ack),
    .h_miss(h_miss), .p_req(p_req), .p_mad_out(p_mad_out), .p_done(p_done));
module tb_top;
    logic clk = 1'b0, rst, paged, p_as, p_accept, p_reject, h_req, h_wide;
    logic h_burst, h_write, h_lock, h_more, h_done, h_sel, h_wide_in;
    logic h_write_in, h_lock_in, h_ack, h_miss, p_req, p_done;
    logic [3:0] page, h_ext_out, h_ext_in;
    logic [35:0] public_memory_base, mem_bound, unit_window_base, unit_bound;
    logic [63:0] p_mad_in, p_mad_out;
    logic [31:0] h_addr_out, h_addr_in;
    logic [6:0] h_len, h_len_in;
    logic [2:0] slow;
    int err_count = 0, tests_run = 0, cycles = 0;
    int lens[8] = '{1, 2, 3, 4, 8, 16, 32, 64};
    pbb_bridge uut (.clk(clk), .rst(rst), .paged(paged), .page(page),
        .public_memory_base(public_memory_base), .mem_bound(mem_bound), .unit_window_base(unit_window_base),
        .unit_bound(unit_bound), .p_as(p_as), .p_mad_in(p_mad_in),
        .p_accept(p_accept), .p_reject(p_reject), .h_req(h_req),
        .h_addr_out(h_addr_out), .h_ext_out(h_ext_out), .h_wide(h_wide),
        .h_len(h_len), .h_burst(h_burst), .h_write(h_write), .h_lock(h_lock),
        .h_more(h_more), .h_done(h_done), .h_sel(h_sel),
        .h_addr_in(h_addr_in), .h_ext_in(h_ext_in), .h_wide_in(h_wide_in),
        .h_len_in(h_len_in), .h_write_in(h_write_in), .h_lock_in(h_lock_in),
        .h_ack(h_ack), .h_miss(h_miss), .p_req(p_req),
        .p_mad_out(p_mad_out), .p_done(p_done));
    pbb_partner far (.clk(clk), .rst(rst), .slow(slow), .h_req(h_req),
        .h_done(h_done), .p_req(p_req), .p_done(p_done));
    always #50 clk = ~clk;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [63:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (err_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic p_op(input logic [35:0] a, input logic [2:0] sz,
                        input logic wr, coh, lk);
        @(negedge clk);
        p_as = 1'b1;
        p_mad_in = {22'h0, lk, coh, wr, sz, a};
        @(negedge clk);
        p_as = 1'b0;
    endtask
    task automatic wait_done();
        for (int n = 0; n < 60 && h_done !== 1'b1; n++) @(negedge clk);
        repeat (2) @(negedge clk);
    endtask
    function automatic logic [2:0] exp_code(int len, logic wide, int i);
        if (wide) return 3'($clog2(len));
        if (len == 3) return i == 0 ? 3'h1 : 3'h0;
        return len >= 4 ? 3'h2 : 3'($clog2(len));
    endfunction
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_proc_sizes();
        for (int c = 0; c < 7; c++) begin
            p_op(36'h300001000 + 36'(c * 256), 3'(c), c[0], 1'b0, c == 2);
            check("accept", p_accept, 1);
            check("length", h_len, 1 << c);
            check("wide", {h_wide, h_burst}, c >= 3 ? 3 : 0);
            check("address", {h_ext_out, h_addr_out}, 36'h300001000 + c * 256);
            check("attrs", {h_write, h_lock}, {c[0], c == 2});
            wait_done();
        end
    endtask
    task automatic s_chain();
        p_op(36'h300004000, 3'h7, 1'b1, 1'b0, 1'b0);
        check("first half", {h_more, h_wide, h_len}, {2'h3, 7'h40});
        wait_done();
        check("second half", {h_req, h_more}, 2);
        check("second addr", h_addr_out, 32'h4040);
        wait_done();
        check("chain released", h_req, 0);
    endtask
    task automatic s_refuse(input logic [35:0] a, input logic coh);
        p_op(a, 3'h2, 1'b0, coh, 1'b0);
        check("refused", {p_reject, p_accept, h_req}, 4);
    endtask
    task automatic h_op(input int len, input logic wide, wr, input logic [3:0] ext);
        logic [2:0] codes[$];
        logic [36:0] first;
        @(negedge clk);
        {h_sel, h_addr_in, h_ext_in} = {1'b1, 32'h100, ext};
        {h_wide_in, h_len_in, h_write_in, h_lock_in} = {wide, 7'(len), wr, wr};
        @(negedge clk);
        h_sel = 1'b0;
        for (int n = 0; n < 300 && h_ack !== 1'b1; n++) begin
            if (p_req === 1'b1 && p_done === 1'b1) begin
                if (codes.size() == 0) first = {p_mad_out[39], p_mad_out[35:0]};
                codes.push_back(p_mad_out[38:36]);
            end
            @(negedge clk);
        end
        check("host ack", h_ack, 1);
        check("first beat", first, {wr, 36'h100000100});
        check("beats", codes.size(), wide ? 1 : len == 3 ? 2 : len < 4 ? 1 : len / 4);
        foreach (codes[i]) check("beat size", codes[i], exp_code(len, wide, i));
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst, paged, page, p_as, p_mad_in, h_sel, slow} = {1'b1, 74'h0};
        {h_addr_in, h_ext_in, h_wide_in, h_len_in} = 44'h0;
        {h_write_in, h_lock_in} = 2'h0;
        {public_memory_base, mem_bound} = {36'h100000000, 36'h10fffffff};
        {unit_window_base, unit_bound} = {36'h200000000, 36'h200ffffff};
        repeat (4) @(negedge clk);
        rst = 1'b0;
        check("reset idle", {h_req, p_req, p_accept, h_ack}, 0);
        s_proc_sizes();
        slow = 3'h3;
        s_chain();
        s_refuse(36'h300000040, 1'b1);
        s_refuse(36'h100000040, 1'b0);
        s_refuse(36'h200000010, 1'b0);
        for (int i = 0; i < 8; i++) h_op(lens[i], 1'b0, i[0], 4'h1);
        slow = 3'h0;
        for (int i = 4; i < 8; i++) h_op(lens[i], 1'b1, i[0], 4'h1);
        @(negedge clk);
        {h_sel, h_ext_in} = {1'b1, 4'h8};
        @(negedge clk);
        h_sel = 1'b0;
        check("host miss", {h_miss, p_req}, 2);
        {paged, page} = {1'b1, 4'h3};
        p_op(36'h300002000, 3'h2, 1'b0, 1'b0, 1'b0);
        check("paged remote", {p_accept, h_addr_out}, {1'b1, 32'h2000});
        wait_done();
        s_refuse(36'h500002000, 1'b0);
        page = 4'h1;
        s_refuse(36'h100000040, 1'b0);
        p_op(36'h120000000, 3'h2, 1'b0, 1'b0, 1'b0);
        check("paged in page", p_accept, 1);
        wait_done();
        h_op(8, 1'b1, 1'b1, 4'h7);
        wrap_up();
    end
endmodule
